// file: logic/cmb_params.svh
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH
// Byte offsets of the buffer words on APB
`define CMB_OFS_STATUS    8'h00
`define CMB_OFS_STAMP     8'h04
`define CMB_OFS_DATA78    8'h08
`define CMB_OFS_DATA56    8'h0c
`define CMB_OFS_DATA34    8'h10
`define CMB_OFS_DATA12    8'h14
`define CMB_OFS_IDLO      8'h18
`define CMB_OFS_IDHI      8'h1c
`define CMB_OFS_LIMIT     8'h20
// Word indexes
`define CMB_IX_STATUS     3'h0
`define CMB_IX_STAMP      3'h1
`define CMB_IX_DATA78     3'h2
`define CMB_IX_DATA56     3'h3
`define CMB_IX_DATA34     3'h4
`define CMB_IX_DATA12     3'h5
`define CMB_IX_IDLO       3'h6
`define CMB_IX_IDHI       3'h7
// Reset value of every buffer word
`define CMB_WORD_RESET    16'h0000
// Status word fields
`define CMB_DLC_HI        15
`define CMB_DLC_LO        12
`define CMB_STATUS_MASK   16'hf0ff
// Identifier high word fields
`define CMB_IDHI_SRR      4
`define CMB_IDHI_IDE      3
// Longest data field in bytes
`define CMB_MAX_BYTES     4'h8
`endif

// file: logic/cmb_pkg.sv
package cmb_pkg;
  typedef logic [15:0] cmb_word_t;
  typedef logic [28:0] cmb_id_t;
  typedef logic [3:0]  cmb_dlc_t;
  typedef logic [63:0] cmb_data_t;
  typedef enum logic [1:0] {
    CMB_TX_IDLE = 2'b00,
    CMB_TX_HOLD = 2'b01
  } cmb_tx_state_t;
endpackage : cmb_pkg

// file: logic/cmb_frame_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cmb_frame_if;
  import cmb_pkg::*;
  logic      ide;
  cmb_id_t   id;
  logic      srr;
  logic      rtr;
  cmb_dlc_t  dlc;
  cmb_data_t data;
  modport src (output ide, id, srr, rtr, dlc, data);
  modport snk (input ide, id, srr, rtr, dlc, data);
endinterface : cmb_frame_if
`default_nettype wire

// file: logic/cmb_apb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module cmb_apb_slave
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic [2:0]       reg_idx,
  output logic             reg_wr,
  output logic [1:0]       reg_lanes,
  input  wire logic [15:0] reg_rdata
);
  `include "cmb_params.svh"
  logic        hit;
  logic [31:0] prdata_reg;

  // Aligned word inside the buffer window
  assign hit       = (paddr < `CMB_OFS_LIMIT) && (paddr[1:0] == 2'b00);
  assign reg_idx   = paddr[4:2];
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !hit;
  assign reg_wr    = psel && penable && pwrite && hit;
  assign reg_lanes = pstrb[1:0];
  assign prdata    = prdata_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_reg <= hit && !pwrite ? {16'h0000, reg_rdata} : 32'h0000_0000;
  end
endmodule : cmb_apb_slave
`default_nettype wire

// file: logic/cmb_frame_pack.sv
`timescale 1ns/100ps
`default_nettype none
module cmb_frame_pack
  import cmb_pkg::*;
(
  input  wire cmb_pkg::cmb_word_t id_hi,
  input  wire cmb_pkg::cmb_word_t id_lo,
  input  wire cmb_pkg::cmb_word_t status,
  input  wire cmb_pkg::cmb_data_t data_in,
  cmb_frame_if.src                tx,
  cmb_frame_if.snk                rx,
  output cmb_pkg::cmb_word_t      rx_id_hi,
  output cmb_pkg::cmb_word_t      rx_id_lo
);
  `include "cmb_params.svh"
  logic      ext;
  cmb_dlc_t  len;
  cmb_data_t keep;

  assign ext = id_hi[`CMB_IDHI_IDE];
  assign tx.ide = ext;
  // Base identifier on top, extension bits below
  assign tx.id = ext ? {id_hi[15:5], id_hi[2:0], id_lo[15:1]}
                     : {18'h00000, id_hi[15:5]};
  assign tx.srr = 1'b1;
  assign tx.rtr = ext ? id_lo[0] : id_hi[`CMB_IDHI_SRR];
  // Length clamped to eight bytes
  assign len = status[`CMB_DLC_HI] ? `CMB_MAX_BYTES
                                   : status[`CMB_DLC_HI:`CMB_DLC_LO];
  assign tx.dlc = len;

  // Unused bytes and remote frame data suppressed
  always_comb
  begin
    keep = 64'h0000_0000_0000_0000;
    for (int b = 0; b < 8; b++)
    begin
      if (b < int'(len) && !tx.rtr)
        keep[63 - 8*b -: 8] = 8'hff;
    end
  end
  assign tx.data = data_in & keep;

  // Received identifier laid out per frame format
  assign rx_id_hi = rx.ide ? {rx.id[28:18], rx.srr, 1'b1, rx.id[17:15]}
                           : {rx.id[10:0], rx.rtr, 1'b0, 3'b000};
  assign rx_id_lo = rx.ide ? {rx.id[14:0], rx.rtr} : 16'h0000;
endmodule : cmb_frame_pack
`default_nettype wire

// file: logic/cmb_buffer.sv
// How it works
// - On transmit only the bytes chosen by the length code are sent; the rest are ignored.
// - On receive the unused byte positions may be filled with whatever the engine supplies.
// - The extension bit picks a standard frame with 11-bit identifier (0) or an extended one (1).
// - For an extended transmit software sets the substitute bit, and the block always sends it as 1.
// - On an extended receive the substitute bit is stored as seen on the bus.
// - The remote bit gives data frame (0) or remote frame (1) in both directions.
// - An extended identifier of 29 bits is built from both identifier words.
// - Identifier bits 28:18 hold the 11-bit base identifier of an extended frame; a standard identifier sits at bits 10:0.
// - The high identifier word holds ID 28:18, substitute bit, extension bit, ID 17:15; a standard frame puts its remote bit in the substitute bit.
// - The data words carry no meaning for a remote frame and are ignored on transmit.
// - A received remote frame may overwrite all four data words.
// - The four-bit length code is set by software to send and reports the received byte count.
// - A length code of eight or above means eight bytes.
`timescale 1ns/100ps
`default_nettype none
module cmb_buffer
  import cmb_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               tx_take,
  input  wire logic               tx_done,
  output logic                    tx_valid,
  output logic                    tx_ide,
  output cmb_pkg::cmb_id_t        tx_id,
  output logic                    tx_srr,
  output logic                    tx_rtr,
  output cmb_pkg::cmb_dlc_t       tx_len,
  output cmb_pkg::cmb_data_t      tx_data,
  input  wire logic               rx_store,
  input  wire logic               rx_ide,
  input  wire cmb_pkg::cmb_id_t   rx_id,
  input  wire logic               rx_srr,
  input  wire logic               rx_rtr,
  input  wire cmb_pkg::cmb_dlc_t  rx_dlc,
  input  wire cmb_pkg::cmb_data_t rx_data,
  input  wire cmb_pkg::cmb_word_t rx_stamp
);
  import cmb_pkg::*;
  `include "cmb_params.svh"

  cmb_word_t     words_reg [8];
  logic [2:0]    reg_idx;
  logic          reg_wr;
  logic [1:0]    reg_lanes;
  cmb_word_t     reg_rdata;
  cmb_word_t     wr_word;
  cmb_word_t     rx_id_hi;
  cmb_word_t     rx_id_lo;
  cmb_data_t     data_words;
  cmb_tx_state_t tx_state_reg;
  cmb_tx_state_t tx_state_next;
  logic          tx_ide_reg;
  cmb_id_t       tx_id_reg;
  logic          tx_srr_reg;
  logic          tx_rtr_reg;
  cmb_dlc_t      tx_len_reg;
  cmb_data_t     tx_data_reg;

  cmb_frame_if tx_frame ();
  cmb_frame_if rx_frame ();

  cmb_apb_slave u_apb
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pstrb     (pstrb),
    .pready    (pready),
    .pslverr   (pslverr),
    .prdata    (prdata),
    .reg_idx   (reg_idx),
    .reg_wr    (reg_wr),
    .reg_lanes (reg_lanes),
    .reg_rdata (reg_rdata)
  );

  // Received frame onto the shared carrier
  assign rx_frame.ide  = rx_ide;
  assign rx_frame.id   = rx_id;
  assign rx_frame.srr  = rx_srr;
  assign rx_frame.rtr  = rx_rtr;
  assign rx_frame.dlc  = rx_dlc;
  assign rx_frame.data = rx_data;

  // Data bytes one to eight, byte one first
  assign data_words = {words_reg[`CMB_IX_DATA12], words_reg[`CMB_IX_DATA34],
                       words_reg[`CMB_IX_DATA56], words_reg[`CMB_IX_DATA78]};

  cmb_frame_pack u_pack
  (
    .id_hi    (words_reg[`CMB_IX_IDHI]),
    .id_lo    (words_reg[`CMB_IX_IDLO]),
    .status   (words_reg[`CMB_IX_STATUS]),
    .data_in  (data_words),
    .tx       (tx_frame),
    .rx       (rx_frame),
    .rx_id_hi (rx_id_hi),
    .rx_id_lo (rx_id_lo)
  );

  // Register read mux, reserved status bits read zero
  always_comb
  begin
    reg_rdata = words_reg[reg_idx];
    if (reg_idx == `CMB_IX_STATUS)
      reg_rdata = words_reg[reg_idx] & `CMB_STATUS_MASK;
  end

  // Byte-lane merge of a software write
  always_comb
  begin
    wr_word = words_reg[reg_idx];
    if (reg_lanes[0])
      wr_word[7:0] = pwdata[7:0];
    if (reg_lanes[1])
      wr_word[15:8] = pwdata[15:8];
  end

  // Buffer words; a frame store from the engine beats a software write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
        words_reg[i] <= `CMB_WORD_RESET;
    end
    else if (rx_store)
    begin
      words_reg[`CMB_IX_IDHI] <= rx_id_hi;
      words_reg[`CMB_IX_IDLO] <= rx_id_lo;
      words_reg[`CMB_IX_STAMP] <= rx_stamp;
      words_reg[`CMB_IX_STATUS][`CMB_DLC_HI:`CMB_DLC_LO] <= rx_dlc;
      // Whole data field written, unused bytes included
      words_reg[`CMB_IX_DATA12] <= rx_data[63:48];
      words_reg[`CMB_IX_DATA34] <= rx_data[47:32];
      words_reg[`CMB_IX_DATA56] <= rx_data[31:16];
      words_reg[`CMB_IX_DATA78] <= rx_data[15:0];
    end
    else if (reg_wr)
      words_reg[reg_idx] <= wr_word;
  end

  // Transmit handshake with the engine
  always_comb
  begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      CMB_TX_IDLE:
        if (tx_take)
          tx_state_next = CMB_TX_HOLD;
      CMB_TX_HOLD:
        if (tx_done)
          tx_state_next = CMB_TX_IDLE;
      default:
        tx_state_next = CMB_TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tx_state_reg <= CMB_TX_IDLE;
    else
      tx_state_reg <= tx_state_next;
  end

  // Frame snapshot held steady while the engine sends
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_ide_reg  <= 1'b0;
      tx_id_reg   <= 29'h0000_0000;
      tx_srr_reg  <= 1'b0;
      tx_rtr_reg  <= 1'b0;
      tx_len_reg  <= 4'h0;
      tx_data_reg <= 64'h0000_0000_0000_0000;
    end
    else if (tx_state_reg == CMB_TX_IDLE && tx_take)
    begin
      tx_ide_reg  <= tx_frame.ide;
      tx_id_reg   <= tx_frame.id;
      tx_srr_reg  <= tx_frame.srr;
      tx_rtr_reg  <= tx_frame.rtr;
      tx_len_reg  <= tx_frame.dlc;
      tx_data_reg <= tx_frame.data;
    end
  end

  assign tx_valid = (tx_state_reg == CMB_TX_HOLD);
  assign tx_ide   = tx_ide_reg;
  assign tx_id    = tx_id_reg;
  assign tx_srr   = tx_srr_reg;
  assign tx_rtr   = tx_rtr_reg;
  assign tx_len   = tx_len_reg;
  assign tx_data  = tx_data_reg;
endmodule : cmb_buffer
`default_nettype wire

// file: verification/cmb_buffer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cmb_buffer_checker
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               tx_valid,
  input wire logic               tx_ide,
  input wire cmb_pkg::cmb_id_t   tx_id,
  input wire logic               tx_srr,
  input wire logic               tx_rtr,
  input wire cmb_pkg::cmb_dlc_t  tx_len,
  input wire cmb_pkg::cmb_data_t tx_data,
  input wire logic               rx_store,
  input wire logic               rx_ide,
  input wire cmb_pkg::cmb_id_t   rx_id,
  input wire logic               rx_srr,
  input wire logic               rx_rtr,
  input wire cmb_pkg::cmb_dlc_t  rx_dlc,
  input wire cmb_pkg::cmb_data_t rx_data
);
  import cmb_pkg::*;
  logic      fresh;
  logic      last_ide;
  logic      last_srr;
  logic      last_rtr;
  cmb_id_t   last_id;
  cmb_dlc_t  last_dlc;
  cmb_data_t last_data;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Last stored frame, trusted until software writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fresh <= 1'b0;
    else if (rx_store)
      fresh <= 1'b1;
    else if (psel && penable && pwrite)
      fresh <= 1'b0;
  end
  always_ff @(posedge core_clk)
  begin
    if (rx_store)
    begin
      last_ide  <= rx_ide;
      last_srr  <= rx_srr;
      last_rtr  <= rx_rtr;
      last_id   <= rx_id;
      last_dlc  <= rx_dlc;
      last_data <= rx_data;
    end
  end
  sequence s_rd(logic [7:0] a);
    fresh && !rx_store && psel && !penable && !pwrite && paddr == a ##1 penable;
  endsequence
  property p_srr; tx_valid |-> tx_srr; endproperty
  property p_len; tx_valid |-> tx_len <= 4'h8; endproperty
  property p_rtr; tx_valid && tx_rtr |-> tx_data == 64'h0; endproperty
  property p_short; tx_valid |-> (tx_data << {tx_len, 3'b000}) == 64'h0; endproperty
  property p_std; tx_valid && !tx_ide |-> tx_id[28:11] == 18'h0; endproperty
  property p_idhi;
    last_ide ##0 s_rd(8'h1c) |->
      prdata[15:0] == {last_id[28:18], last_srr, 1'b1, last_id[17:15]};
  endproperty
  property p_idlo;
    last_ide ##0 s_rd(8'h18) |-> prdata[15:0] == {last_id[14:0], last_rtr};
  endproperty
  property p_dlc; s_rd(8'h00) |-> prdata[15:12] == last_dlc; endproperty
  property p_data; s_rd(8'h14) |-> prdata[15:0] == last_data[63:48]; endproperty
  a_srr: assert property (p_srr)
    else $error("substitute bit not sent as one");
  a_len: assert property (p_len)
    else $error("length above eight");
  a_rtr: assert property (p_rtr)
    else $error("remote frame carries data");
  a_short: assert property (p_short)
    else $error("unused bytes sent");
  a_std: assert property (p_std)
    else $error("standard identifier too wide");
  a_idhi: assert property (p_idhi)
    else $error("high identifier word wrong");
  a_idlo: assert property (p_idlo)
    else $error("low identifier word wrong");
  a_dlc: assert property (p_dlc)
    else $error("received length not stored");
  a_data: assert property (p_data)
    else $error("first data bytes misplaced");
  c_ext_rtr: cover property (tx_valid && tx_ide && tx_rtr);
  c_std: cover property (tx_valid && !tx_ide);
  c_rx_ext: cover property (rx_store && rx_ide);
endmodule : cmb_buffer_checker
bind cmb_buffer cmb_buffer_checker u_chk (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .tx_valid, .tx_ide, .tx_id, .tx_srr, .tx_rtr, .tx_len, .tx_data,
  .rx_store, .rx_ide, .rx_id, .rx_srr, .rx_rtr, .rx_dlc, .rx_data);
`default_nettype wire

// file: verification/cmb_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmb_engine_model
(
  input  wire logic           core_clk,
  input  wire logic           tx_valid,
  output logic                tx_take,
  output logic                tx_done,
  output logic                rx_store,
  output logic                rx_ide,
  output cmb_pkg::cmb_id_t    rx_id,
  output logic                rx_srr,
  output logic                rx_rtr,
  output cmb_pkg::cmb_dlc_t   rx_dlc,
  output cmb_pkg::cmb_data_t  rx_data,
  output cmb_pkg::cmb_word_t  rx_stamp
);
  import cmb_pkg::*;
  initial
  begin
    {tx_take, tx_done, rx_store, rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data, rx_stamp} = '0;
  end
  // Request a snapshot and wait for it
  task automatic take();
    int n;
    n = 0;
    @(posedge core_clk);
    tx_take <= 1'b1;
    @(posedge core_clk);
    tx_take <= 1'b0;
    while (tx_valid !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : take
  // Finish sending after a chosen delay
  task automatic send_done(input int gap);
    repeat (gap) @(posedge core_clk);
    tx_done <= 1'b1;
    @(posedge core_clk);
    tx_done <= 1'b0;
  endtask : send_done
  // Store a frame; substitute bit as seen on the bus, junk in unused bytes
  task automatic store(input logic ide, input cmb_id_t id, input logic srr, input logic rtr,
                       input cmb_dlc_t dlc, input cmb_data_t d);
    @(posedge core_clk);
    rx_store <= 1'b1;
    {rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data, rx_stamp} <=
      {ide, id, srr, rtr, dlc, d, 16'h5a3c};
    @(posedge core_clk);
    rx_store <= 1'b0;
    {rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data} <= ~{ide, id, srr, rtr, dlc, d};
  endtask : store
endmodule : cmb_engine_model
`default_nettype wire

// file: verification/cmb_buffer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cmb_buffer_tb;
  import cmb_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        tx_take, tx_done, tx_valid, tx_ide, tx_srr, tx_rtr, e;
  logic        rx_store, rx_ide, rx_srr, rx_rtr;
  cmb_id_t     tx_id, rx_id;
  cmb_dlc_t    tx_len, rx_dlc;
  cmb_data_t   tx_data, rx_data;
  cmb_word_t   rx_stamp;
  int          n_fail, checks_done, cyc;
  cmb_buffer uut (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .tx_take, .tx_done, .tx_valid, .tx_ide, .tx_id, .tx_srr, .tx_rtr,
    .tx_len, .tx_data, .rx_store, .rx_ide, .rx_id, .rx_srr, .rx_rtr, .rx_dlc, .rx_data, .rx_stamp);
  cmb_engine_model eng (.core_clk, .tx_valid, .tx_take, .tx_done, .rx_store, .rx_ide, .rx_id,
    .rx_srr, .rx_rtr, .rx_dlc, .rx_data, .rx_stamp);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 16'h0, d, 4'hf};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic t_std_tx();
    logic [63:0] m;
    apb(1, 8'h1c, {11'h5a3, 2'b00, 3'b111});
    for (int i = 0; i < 4; i++)
      apb(1, 8'h08 + 8'(4 * i), {8'(8'h11 * (7 - 2 * i)), 8'(8'h11 * (8 - 2 * i))});
    for (int d = 0; d < 16; d++)
    begin
      apb(1, 8'h00, {4'(d), 12'h0});
      eng.take();
      m = ~(64'hffffffffffffffff >> (8 * (d > 8 ? 8 : d)));
      chk("tx_len", tx_len, d > 8 ? 8 : d);
      chk("tx_data", tx_data, 64'h1122334455667788 & m);
      chk("tx_id", tx_id, {18'h0, 11'h5a3});
      chk("tx_flags", {tx_ide, tx_rtr, tx_srr}, 3'b001);
      eng.send_done(d % 3);
    end
    $display("test std_tx done");
  endtask : t_std_tx
  task automatic t_ext_rtr();
    cmb_id_t id;
    id = 29'h1abcdef5;
    // Stored substitute bit cleared to show it is forced on the wire
    apb(1, 8'h1c, {id[28:18], 2'b01, id[17:15]});
    apb(1, 8'h18, {id[14:0], 1'b1});
    apb(1, 8'h00, 16'hf000);
    eng.take();
    chk("ext_id", tx_id, id);
    chk("ext_flags", {tx_ide, tx_rtr, tx_srr}, 3'b111);
    chk("ext_len", tx_len, 8);
    chk("ext_data", tx_data, 0);
    eng.send_done(0);
    $display("test ext_rtr done");
  endtask : t_ext_rtr
  task automatic t_rx();
    eng.store(1, 29'h0f0f1234, 0, 0, 4'h2, 64'hdeadbeef0badf00d);
    apb(0, 8'h1c, 0);
    chk("rx_idhi", q, {16'h0, 11'h3c3, 2'b01, 3'h6});
    apb(0, 8'h18, 0);
    chk("rx_idlo", q, {16'h0, 15'h1234, 1'b0});
    apb(0, 8'h00, 0);
    chk("rx_dlc", q[15:12], 4'h2);
    apb(0, 8'h14, 0);
    chk("rx_b12", q, 32'hdead);
    apb(0, 8'h08, 0);
    chk("rx_b78", q, 32'hf00d);
    eng.store(0, 29'h7ff, 1, 1, 4'h0, 64'h0123456789abcdef);
    apb(0, 8'h1c, 0);
    chk("rx_std_hi", q, 32'hfff0);
    apb(0, 8'h0c, 0);
    chk("rx_rtr_b56", q, 32'h89ab);
    apb(0, 8'h20, 0);
    chk("unmapped", {e, q}, 33'h100000000);
    $display("test rx done");
  endtask : t_rx
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    {core_clk, rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {2'b01, 47'h0};
    {n_fail, checks_done, cyc} = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_std_tx();
    t_ext_rtr();
    t_rx();
    test_done();
  end
endmodule : cmb_buffer_tb
`default_nettype wire
